// file: common/flash_lock_defs.svh
// Constants for the global lock and two-step soft reset command block.
// Assumes a 125 MHz system clock sampling a slow host serial link.

`ifndef FLASH_LOCK_DEFS_SVH
`define FLASH_LOCK_DEFS_SVH

// ********************************************************
// Opcodes
// ********************************************************
`define OP_GLOBAL_LOCK 8'h7e
`define OP_GLOBAL_UNLOCK 8'h98
`define OP_RESET_ARM 8'h66
`define OP_RESET_EXEC 8'h99

// ********************************************************
// Register map, byte addresses
// ********************************************************
`define OFS_CTRL 8'h00
`define OFS_VOLATILE 8'h04
`define OFS_LOCKS 8'h08
`define OFS_STATUS 8'h0c

// Field positions
`define CTRL_FOUR_LINE_BIT 0
`define STAT_ARMED_BIT 0
`define STAT_RECOVER_BIT 1
`define STAT_PUW_DONE_BIT 2
`define STAT_LAST_OP_LSB 8

// Reset values and sizes
`define LOCK_COUNT 16
`define LOCK_ALL_SET 16'hffff
`define LOCK_ALL_CLEAR 16'h0000
`define VOL_RESET 24'h000000

// ********************************************************
// Timing
// ********************************************************
`define CLK_PERIOD_NS 8
`define RECOVER_TIME_NS 30000
`define RECOVER_CNT_W 12
`define PUW_TIME_MS 5
`define PUW_CNT_W 20

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: common/flash_lock_pkg.sv
// Types shared by the opcode capture and the command interpreter.
// Assumes flash_lock_defs.svh is compiled alongside.

package flash_lock_pkg;

	// Arm state; gray steps idle -> armed -> recovering
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_RECOVER = 2'b11
	} arm_state_t;

	// One finished frame seen on the serial link
	typedef struct packed {
		logic valid;
		logic whole;
		logic [7:0] opcode;
	} frame_t;

	// Volatile settings wiped by a soft reset
	typedef struct packed {
		logic [7:0] continuous_mode_bits;
		logic [7:0] read_param_bits;
		logic spare;
		logic [2:0] wrap_setting_bits;
		logic volatile_status;
		logic busy;
		logic suspend_flag;
		logic write_enable_latch;
	} volatile_t;

endpackage

// file: logic/serial_opcode_capture.sv
// Samples the host select, serial clock and data lines and assembles
// the first byte of each frame. Assumes all pins are asynchronous.
`timescale 1ns/100ps
`include "flash_lock_defs.svh"

module serial_opcode_capture import flash_lock_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	input wire logic four_line_command_mode,
	output frame_t frame
);

	// ********************************************************
	// Synchronisers
	// ********************************************************
	logic [5:0] pin_meta; // First stage, read only by second
	logic [5:0] pin_sync; // {cs_n, sclk, io}
	logic cs_prev; // Edge detect history
	logic sclk_prev;

	// Two flops per pin, then one history flop for edges
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Select high, clock low: the idle levels of the pins
			pin_meta <= 6'h20;
			pin_sync <= 6'h20;
			cs_prev <= 1'b1;
			sclk_prev <= 1'b0;
		end else begin
			pin_meta <= {cs_n, sclk, io_in};
			pin_sync <= pin_meta;
			cs_prev <= pin_sync[5];
			sclk_prev <= pin_sync[4];
		end
	end

	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	assign cs_low = !pin_sync[5];
	assign cs_fall = cs_prev && !pin_sync[5];
	assign cs_rise = !cs_prev && pin_sync[5];
	assign sclk_rise = pin_sync[4] && !sclk_prev && cs_low;

	// ********************************************************
	// Shifter
	// ********************************************************
	logic [7:0] shreg; // Opcode being assembled
	logic [4:0] nbits; // Bits seen, saturates at 16
	frame_t next_frame;
	logic [7:0] next_shreg;
	logic [4:0] next_nbits;

	// Shift one or four bits per edge; only the first byte is kept
	always_comb begin
		next_shreg = shreg;
		next_nbits = nbits;
		next_frame = '0;
		if (cs_fall) begin
			next_nbits = 5'h00;
		end else if (sclk_rise && nbits < 5'h10) begin
			if (four_line_command_mode) begin
				if (nbits < 5'h08) begin
					next_shreg = {shreg[3:0], pin_sync[3:0]};
				end
				next_nbits = nbits + 5'h04;
			end else begin
				if (nbits < 5'h08) begin
					next_shreg = {shreg[6:0], pin_sync[0]};
				end
				next_nbits = nbits + 5'h01;
			end
		end
		// Frame ends on select release; empty frames are dropped
		if (cs_rise && nbits != 5'h00) begin
			next_frame.valid = 1'b1;
			next_frame.whole = (nbits == 5'h08);
			next_frame.opcode = shreg;
		end
	end

	// Register the shifter and the frame pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= 8'h00;
			nbits <= 5'h00;
			frame <= '0;
		end else begin
			shreg <= next_shreg;
			nbits <= next_nbits;
			frame <= next_frame;
		end
	end

endmodule

// file: logic/flash_lock_top.sv
// Global lock/unlock and two-step soft reset interpreter with an
// AXI4-Lite register port. Assumes the host drives the serial pins.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "flash_lock_defs.svh"

module flash_lock_top import flash_lock_pkg::*; #(
	// Power-up write delay in cycles, shorten for simulation
	parameter int unsigned PUW_CYCLES = (`PUW_TIME_MS * 1000000 +
		`CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [`LOCK_COUNT-1:0] lock_bits,
	output logic powerup_write_ok
);

	localparam int unsigned RECOVER_CYC =
		`RECOVER_TIME_NS / `CLK_PERIOD_NS;

	// ********************************************************
	// Helpers
	// ********************************************************
	// Address decode shared by reads and writes
	function automatic logic mapped(input logic [7:0] a);
		return a == `OFS_CTRL || a == `OFS_VOLATILE ||
			a == `OFS_LOCKS || a == `OFS_STATUS;
	endfunction

	// Byte lane merge for software writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ********************************************************
	// Link capture
	// ********************************************************
	logic four_line_command_mode; // Software selected line mode
	frame_t frame; // One-cycle frame report

	serial_opcode_capture capture (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.io_in(io_in),
		.four_line_command_mode(four_line_command_mode),
		.frame(frame)
	);

	// ********************************************************
	// Command interpreter
	// ********************************************************
	arm_state_t state, next_state;
	logic [`RECOVER_CNT_W-1:0] rec_cnt, next_rec_cnt;
	logic [`LOCK_COUNT-1:0] next_lock_bits;
	logic [7:0] last_op, next_last_op; // Last accepted opcode
	logic accepted; // Frame arrives outside recovery
	logic soft_rst; // Reset pair completed

	// Frames during recovery are dropped whole
	assign accepted = frame.valid && state != ST_RECOVER;
	assign soft_rst = accepted && state == ST_ARMED && frame.whole &&
		frame.opcode == `OP_RESET_EXEC;

	// Next arm state, recovery count and protection bits
	always_comb begin
		next_state = state;
		next_rec_cnt = rec_cnt;
		next_lock_bits = lock_bits;
		next_last_op = last_op;
		if (accepted) begin
			next_last_op = frame.opcode;
			if (frame.whole && frame.opcode == `OP_GLOBAL_LOCK) begin
				next_lock_bits = `LOCK_ALL_SET;
			end else if (frame.whole &&
				frame.opcode == `OP_GLOBAL_UNLOCK) begin
				next_lock_bits = `LOCK_ALL_CLEAR;
			end
		end
		case (state)
			ST_IDLE: begin
				if (accepted && frame.whole &&
					frame.opcode == `OP_RESET_ARM) begin
					next_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (soft_rst) begin
					// Abort and start the blind period
					next_state = ST_RECOVER;
					next_rec_cnt = RECOVER_CYC[`RECOVER_CNT_W-1:0];
					next_lock_bits = `LOCK_ALL_SET;
				end else if (accepted && !(frame.whole &&
					frame.opcode == `OP_RESET_ARM)) begin
					next_state = ST_IDLE;
				end
			end
			ST_RECOVER: begin
				next_rec_cnt = rec_cnt - 1'b1;
				if (rec_cnt <= 1) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Power-up leaves the array locked and disarmed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			rec_cnt <= '0;
			lock_bits <= `LOCK_ALL_SET;
			last_op <= 8'h00;
		end else begin
			state <= next_state;
			rec_cnt <= next_rec_cnt;
			lock_bits <= next_lock_bits;
			last_op <= next_last_op;
		end
	end

	// ********************************************************
	// Power-up write delay
	// ********************************************************
	logic [`PUW_CNT_W-1:0] pu_cnt, next_pu_cnt;
	logic next_pu_done;

	// Count once from power-up; a soft reset does not restart it
	always_comb begin
		next_pu_cnt = pu_cnt;
		if (pu_cnt != PUW_CYCLES[`PUW_CNT_W-1:0]) begin
			next_pu_cnt = pu_cnt + 1'b1;
		end
		next_pu_done = next_pu_cnt == PUW_CYCLES[`PUW_CNT_W-1:0];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pu_cnt <= '0;
			powerup_write_ok <= 1'b0;
		end else begin
			pu_cnt <= next_pu_cnt;
			powerup_write_ok <= next_pu_done;
		end
	end

	// ********************************************************
	// AXI4-Lite slave and software registers
	// ********************************************************
	logic aw_got, next_aw_got; // Write address held
	logic w_got, next_w_got; // Write data held
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic next_four_line;
	volatile_t vol, next_vol; // Settings wiped by soft reset
	logic do_write; // Both halves present, response free
	logic [31:0] rd_word;
	logic [31:0] wr_word; // Write data merged by byte lane

	// One write and one read in flight; channels held until taken
	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_got && w_got && !s_axi_bvalid;

	// Bus next state and register updates
	always_comb begin
		wr_word = 32'h0000_0000;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		next_four_line = four_line_command_mode;
		next_vol = vol;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
			if (aw_addr == `OFS_CTRL) begin
				wr_word = merge({31'h0, four_line_command_mode}, w_data,
					w_strb);
				next_four_line = wr_word[`CTRL_FOUR_LINE_BIT];
			end else if (aw_addr == `OFS_VOLATILE) begin
				wr_word = merge({8'h00, vol}, w_data, w_strb);
				next_vol = volatile_t'(wr_word[23:0]);
				next_vol.spare = 1'b0;
			end
		end
		// Soft reset beats a software write in the same cycle
		if (soft_rst) begin
			next_vol = volatile_t'(`VOL_RESET);
		end
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`OFS_CTRL: rd_word[`CTRL_FOUR_LINE_BIT] = four_line_command_mode;
			`OFS_VOLATILE: rd_word[23:0] = vol;
			`OFS_LOCKS: rd_word[`LOCK_COUNT-1:0] = lock_bits;
			`OFS_STATUS: begin
				rd_word[`STAT_ARMED_BIT] = state == ST_ARMED;
				rd_word[`STAT_RECOVER_BIT] = state == ST_RECOVER;
				rd_word[`STAT_PUW_DONE_BIT] = powerup_write_ok;
				rd_word[`STAT_LAST_OP_LSB +: 8] = last_op;
			end
			default: rd_word = 32'h0000_0000;
		endcase
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			four_line_command_mode <= 1'b0;
			vol <= volatile_t'(`VOL_RESET);
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			four_line_command_mode <= next_four_line;
			vol <= next_vol;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic cmd_lock, cmd_unlock, cmd_exec;
	assign cmd_lock = frame.valid && frame.whole &&
		frame.opcode == `OP_GLOBAL_LOCK;
	assign cmd_unlock = frame.valid && frame.whole &&
		frame.opcode == `OP_GLOBAL_UNLOCK;
	assign cmd_exec = frame.valid && frame.whole &&
		frame.opcode == `OP_RESET_EXEC;

	sequence s_reset_taken;
		state == ST_ARMED && cmd_exec;
	endsequence
	sequence s_blind;
		(state == ST_RECOVER)[*8];
	endsequence

	a_global_lock: assert property (
		cmd_lock && state != ST_RECOVER |=> lock_bits == `LOCK_ALL_SET)
		else $error("global lock left bits open");
	a_global_unlock: assert property (
		cmd_unlock && state != ST_RECOVER |=>
		lock_bits == `LOCK_ALL_CLEAR)
		else $error("global unlock left bits set");
	a_reset_wipes: assert property (
		s_reset_taken |=> vol == volatile_t'(`VOL_RESET) ##0 s_blind)
		else $error("reset did not wipe volatile state");
	a_exec_any_mode: assert property (
		s_reset_taken |=> state == ST_RECOVER)
		else $error("reset pair refused in current line mode");
	a_exec_needs_arm: assert property (
		state == ST_IDLE && cmd_exec |=> state == ST_IDLE)
		else $error("reset taken without arm");
	a_arm_dropped: assert property (
		state == ST_ARMED && frame.valid && !cmd_exec &&
		!(frame.whole && frame.opcode == `OP_RESET_ARM) |=>
		state == ST_IDLE)
		else $error("armed state kept after other command");
	a_blind_load: assert property (
		soft_rst |=> rec_cnt == RECOVER_CYC[`RECOVER_CNT_W-1:0])
		else $error("recovery time wrong");
	a_blind_ignore: assert property (
		state == ST_RECOVER && frame.valid |=>
		$stable(lock_bits) && $stable(last_op))
		else $error("command acted on during recovery");
	a_reset_locks: assert property (
		soft_rst |=> lock_bits == `LOCK_ALL_SET)
		else $error("reset left array unlocked");
	a_rearm_needed: assert property (
		state == ST_RECOVER && rec_cnt == 1 |=> state == ST_IDLE)
		else $error("recovery did not end disarmed");

endmodule

// file: bench/host_serial_model.sv
// Host controller model: sends one opcode frame per select.
// Assumes the bench calls send() from one sequence at a time.
`timescale 1ns/100ps

module host_serial_model (
	input wire logic ref_clk,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_in
);
	// ****************************************
	// Idle levels at time zero
	// ****************************************
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'h5;
	end

	// Opcode alone inside one select, no address phase
	// Same framing in single-line and four-line mode
	// Clock stands low outside frames, 160 ns period inside
	task automatic send(input logic [7:0] op, input int nbits,
		input logic quad);
		int i;
		logic [7:0] sh;
		sh = op;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (i = 0; i < nbits; i += (quad ? 4 : 1)) begin
			// Data changes while the clock is low
			io_in <= quad ? sh[7:4] : {~io_in[3:1], sh[7]};
			sh = quad ? sh << 4 : sh << 1;
			repeat (10) @(posedge ref_clk);
			sclk <= 1'b1;
			repeat (10) @(posedge ref_clk);
			sclk <= 1'b0;
		end
		repeat (5) @(posedge ref_clk);
		cs_n <= 1'b1;
		// Released lines must not keep showing the last bit
		io_in <= ~io_in;
		// Gap lets the command land before the next select
		repeat (10) @(posedge ref_clk);
	endtask
endmodule

// file: bench/flash_lock_top_test.sv
// Bench for the lock and soft reset block: AXI tasks plus host frames.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/100ps
`include "flash_lock_defs.svh"

module flash_lock_top_test;
	// ****************************************
	// Signals
	// ****************************************
	logic ref_clk, rst_n;
	wire cs_n, sclk;
	wire [3:0] io_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [`LOCK_COUNT-1:0] lock_bits;
	wire powerup_write_ok;
	int n_errors, checks_done, q;
	logic [31:0] rd;
	logic [1:0] rs;

	// Short power-up delay keeps the run brief
	flash_lock_top #(.PUW_CYCLES(50)) u_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .lock_bits(lock_bits),
		.powerup_write_ok(powerup_write_ok));

	host_serial_model u_host (.ref_clk(ref_clk), .cs_n(cs_n),
		.sclk(sclk), .io_in(io_in));

	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ****************************************
	// Reporting
	// ****************************************
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// A wait that never ends counts as a mismatch
	task automatic give_up(input string what);
		n_errors++;
		$display("MISMATCH %s expected answer seen timeout", what);
		results();
	endtask

	// ****************************************
	// AXI4-Lite master; ready sampled at the falling edge
	// ****************************************
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] exp_resp);
		int n;
		logic aw_hit, w_hit;
		logic aw_pend, w_pend;
		n = 0;
		aw_pend = 1'b1;
		w_pend = 1'b1;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge ref_clk);
			aw_hit = aw_pend && s_axi_awready;
			w_hit = w_pend && s_axi_wready;
			@(posedge ref_clk);
			// Each half is released at the edge that takes it
			if (aw_hit) begin
				aw_pend = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_hit) begin
				w_pend = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (++n > 50) give_up("write address or data");
		end while (aw_pend || w_pend);
		do begin
			@(negedge ref_clk);
			if (++n > 100) give_up("write response");
		end while (s_axi_bvalid !== 1'b1);
		check("bresp", {30'h0, exp_resp}, {30'h0, s_axi_bresp});
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic hit;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			hit = s_axi_arready;
			@(posedge ref_clk);
			if (++n > 50) give_up("read address");
		end while (!hit);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge ref_clk);
			if (++n > 100) give_up("read data");
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask

	// Masked register compare
	task automatic rd_check(input string what, input logic [7:0] a,
		input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		check(what, exp, d & mask);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		// Power-up state
		check("lock pins", 32'hffff, {16'h0, lock_bits});
		check("write ok", 32'h0, {31'h0, powerup_write_ok});
		rd_check("locks", `OFS_LOCKS, 32'hffff, 32'hffff);
		rd_check("status", `OFS_STATUS, 32'h0, 32'h3);
		axi_read(8'h20, rd, rs);
		check("unmapped rresp", `RESP_SLVERR, {30'h0, rs});
		axi_write(8'h20, 32'h1, `RESP_SLVERR);
		// Host holds off writes until the delay has run
		for (q = 0; q < 200 && powerup_write_ok !== 1'b1; q++) begin
			@(posedge ref_clk);
		end
		check("write ok", 32'h1, {31'h0, powerup_write_ok});
		$display("Test power-up done");
		// Global commands and reset pair in both line modes
		for (q = 0; q < 2; q++) begin
			axi_write(`OFS_CTRL, q, `RESP_OKAY);
			u_host.send(`OP_GLOBAL_UNLOCK, 8, q[0]);
			check("unlock", 32'h0, {16'h0, lock_bits});
			u_host.send(`OP_GLOBAL_LOCK, 8, q[0]);
			check("lock", 32'hffff, {16'h0, lock_bits});
			u_host.send(`OP_GLOBAL_UNLOCK, 8, q[0]);
			axi_write(`OFS_VOLATILE, 32'hffffffff, `RESP_OKAY);
			// Spare bit reads back zero, every other field as written
			rd_check("volatile", `OFS_VOLATILE, 32'hffff7f, '1);
			u_host.send(`OP_RESET_ARM, 8, q[0]);
			rd_check("armed", `OFS_STATUS, 32'h6605, 32'hff07);
			u_host.send(`OP_RESET_EXEC, 8, q[0]);
			check("reset locks", 32'hffff, {16'h0, lock_bits});
			rd_check("wiped", `OFS_VOLATILE, 32'h0, '1);
			rd_check("recover", `OFS_STATUS, 32'h2, 32'h3);
			rd_check("mode kept", `OFS_CTRL, q, 32'h1);
			u_host.send(`OP_GLOBAL_UNLOCK, 8, q[0]);
			check("ignored", 32'hffff, {16'h0, lock_bits});
			// Host stays quiet for the rest of recovery
			repeat (3750) @(posedge ref_clk);
			u_host.send(`OP_GLOBAL_UNLOCK, 8, q[0]);
			check("recovered", 32'h0, {16'h0, lock_bits});
		end
		$display("Test line modes done");
		// Any other frame between arm and execute drops the arm
		axi_write(`OFS_CTRL, 32'h0, `RESP_OKAY);
		// Only the low byte lane may land
		s_axi_wstrb <= 4'h1;
		axi_write(`OFS_VOLATILE, 32'hffffff01, `RESP_OKAY);
		u_host.send(`OP_RESET_ARM, 8, 1'b0);
		u_host.send(`OP_GLOBAL_UNLOCK, 8, 1'b0);
		rd_check("disarmed", `OFS_STATUS, 32'h0, 32'h3);
		u_host.send(`OP_RESET_EXEC, 8, 1'b0);
		rd_check("no reset", `OFS_VOLATILE, 32'h1, '1);
		u_host.send(`OP_RESET_ARM, 8, 1'b0);
		u_host.send(`OP_RESET_EXEC, 4, 1'b0);
		u_host.send(`OP_RESET_EXEC, 8, 1'b0);
		rd_check("short frame", `OFS_VOLATILE, 32'h1, '1);
		check("locks kept", 32'h0, {16'h0, lock_bits});
		$display("Test disarm done");
		results();
	end
endmodule
